// File: hw/kel_pkg.sv
/*
 * Constants, types and shared decode helpers of the keypad edge/level interrupt unit.
 * Assumes a single bus clock domain and an 8-bit register port.
 */
`default_nettype none

package kel_pkg;

   localparam int KEL_MAX_PINS = 8;
   localparam int KEL_DATA_W   = 8;
   localparam int KEL_ADDR_W   = 2;

   typedef logic [KEL_DATA_W-1:0] kel_byte_t;
   typedef logic [KEL_ADDR_W-1:0] kel_addr_t;

   // register offsets
   localparam kel_addr_t KEL_OFS_STATUS_CTRL = 2'h0;
   localparam kel_addr_t KEL_OFS_PIN_ENABLE  = 2'h1;
   localparam kel_addr_t KEL_OFS_POLARITY    = 2'h2;

   // key_status_control field positions
   localparam int KEL_SC_FLAG_BIT = 3;
   localparam int KEL_SC_ACK_BIT  = 2;
   localparam int KEL_SC_IE_BIT   = 1;
   localparam int KEL_SC_MODE_BIT = 0;

   // reset values
   localparam logic      KEL_FLAG_RST = 1'b0;
   localparam logic      KEL_IE_RST   = 1'b0;
   localparam logic      KEL_MODE_RST = 1'b0;
   localparam kel_byte_t KEL_PE_RST   = 8'h00;
   localparam kel_byte_t KEL_ES_RST   = 8'h00;
   localparam kel_byte_t KEL_ZERO     = 8'h00;

   // detection mode encodings
   localparam logic KEL_MODE_EDGE       = 1'b0;
   localparam logic KEL_MODE_EDGE_LEVEL = 1'b1;

   typedef enum {KEL_PWR_RUN, KEL_PWR_LIGHT, KEL_PWR_DEEP} kel_pwr_t;

   // per-pin asserted level: polarity 0 means low is asserted, 1 means high
   function automatic logic kel_asserted(input logic sample, input logic pol);
      kel_asserted = ~(sample ^ pol);
   endfunction

   function automatic logic kel_hit(input kel_addr_t addr, input kel_addr_t ofs);
      kel_hit = (addr == ofs);
   endfunction

endpackage

`default_nettype wire

// File: hw/kel_det_if.sv
/*
 * Interface between the register/control top and the per-pin detector.
 * Assumes both ends run on the same bus clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface kel_det_if #(
   parameter int NUM_PINS = 8
);
   logic [NUM_PINS-1:0] pins;
   logic [NUM_PINS-1:0] enable;
   logic [NUM_PINS-1:0] polarity;
   logic                clear;
   logic [NUM_PINS-1:0] edge_hit;
   logic [NUM_PINS-1:0] level_hit;

   modport ctrl (output pins, output enable, output polarity, output clear,
                 input edge_hit, input level_hit);
   modport det  (input pins, input enable, input polarity, input clear,
                 output edge_hit, output level_hit);
endinterface

`default_nettype wire

// File: hw/kel_detect.sv
/*
 * Per-pin edge and level detector of the keypad interrupt unit.
 * Assumes key inputs are already synchronous to the bus clock.
 */
`timescale 1ns/1ps
`default_nettype none

module kel_detect #(
   parameter int NUM_PINS = 8
) (
   input  wire logic clock,    // bus clock
   input  wire logic reset_n,  // async reset, active low
   kel_det_if.det    dif       // pins, config and hit vectors
);
   import kel_pkg::*;

   logic [NUM_PINS-1:0] prev_r;
   logic [NUM_PINS-1:0] prev_nxt;

   always_comb begin
      // deep stop wipes history so no stale edge appears on wake
      prev_nxt = dif.clear ? '0 : dif.pins;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prev_r <= '0;
      end else begin
         prev_r <= prev_nxt;
      end
   end

   genvar i;
   generate
      for (i = 0; i < NUM_PINS; i++) begin : g_pin
         logic now_on;
         logic was_on;
         assign now_on = kel_asserted(dif.pins[i], dif.polarity[i]);
         assign was_on = kel_asserted(prev_r[i], dif.polarity[i]);
         // previous sample deasserted, present sample asserted
         assign dif.edge_hit[i]  = dif.enable[i] & ~was_on & now_on;
         assign dif.level_hit[i] = dif.enable[i] & now_on;
      end
   endgenerate

endmodule

`default_nettype wire

// File: hw/kel_top.sv
/*
 * Keypad edge/level interrupt unit: register port, detect flag, interrupt
 * request, wake request, pull steering and stop-mode handling.
 * Assumes key inputs and all control inputs are synchronous to clock, and
 * that the bus master never asserts read and write strobes together.
 * Assumes the bus clock keeps running in light stop; deep stop is signalled
 * on stop_deep and acts as a synchronous reset while it lasts.
 */
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module kel_top #(
   parameter int NUM_PINS = kel_pkg::KEL_MAX_PINS
) (
   input  wire  logic                clock,            // 125 MHz bus clock
   input  wire  logic                reset_n,          // async reset, active low
   input  wire  kel_pkg::kel_addr_t  reg_addr,         // register address
   input  wire  kel_pkg::kel_byte_t  reg_wdata,        // write data
   input  wire  logic                reg_wr,           // write strobe
   input  wire  logic                reg_rd,           // read strobe
   output var   kel_pkg::kel_byte_t  reg_rdata,        // read data, cycle after strobe
   input  wire  logic [NUM_PINS-1:0] key_input_pins,   // key inputs, bus-clock synchronous
   input  wire  logic [NUM_PINS-1:0] port_pull_enable, // pad pull enables from the port
   input  wire  logic                stop_light,       // light stop mode active
   input  wire  logic                stop_deep,        // either deep stop mode active
   output logic                      irq_request,      // interrupt request to CPU
   output logic                      wake_request,     // wake request while in light stop
   output logic [NUM_PINS-1:0]       pull_up_en,       // pad pull-up enable
   output logic [NUM_PINS-1:0]       pull_dn_en        // pad pull-down enable
);
   import kel_pkg::*;

   // the byte-wide register port cannot carry more than eight pins
   generate
      if (NUM_PINS < 1 || NUM_PINS > KEL_MAX_PINS) begin : g_bad_pins
         $error("kel_top: NUM_PINS must lie between 1 and 8");
      end
   endgenerate

   // pin registers read back with zeros above the implemented pins
   function automatic kel_byte_t pin_word(input logic [NUM_PINS-1:0] bits);
      pin_word               = KEL_ZERO;
      pin_word[NUM_PINS-1:0] = bits;
   endfunction

   // power state
   kel_pwr_t pwr_r;
   kel_pwr_t pwr_nxt;
   logic     deep_clear;

   // software-visible state
   logic                flag_r;
   logic                flag_nxt;
   logic                ie_r;
   logic                ie_nxt;
   logic                mode_r;
   logic                mode_nxt;
   logic [NUM_PINS-1:0] pe_r;
   logic [NUM_PINS-1:0] pe_nxt;
   logic [NUM_PINS-1:0] es_r;
   logic [NUM_PINS-1:0] es_nxt;

   // registered outputs
   kel_byte_t           rdata_r;
   kel_byte_t           rdata_nxt;
   logic                irq_r;
   logic                irq_nxt;
   logic                wake_r;
   logic                wake_nxt;
   logic [NUM_PINS-1:0] pull_up_r;
   logic [NUM_PINS-1:0] pull_up_nxt;
   logic [NUM_PINS-1:0] pull_dn_r;
   logic [NUM_PINS-1:0] pull_dn_nxt;

   // decode and detection terms
   logic wr_sc;
   logic wr_pe;
   logic wr_es;
   logic ack_req;
   logic set_cond;
   logic edge_any;
   logic level_any;
   logic clear_ok;

   // the detector keeps its own sample history; the top only reads back
   // its per-pin hit vectors and decides what they do to the flag
   kel_det_if #(.NUM_PINS(NUM_PINS)) dif ();

   assign dif.pins     = key_input_pins;
   assign dif.enable   = pe_r;
   assign dif.polarity = es_r;
   assign dif.clear    = deep_clear;

   kel_detect #(
      .NUM_PINS (NUM_PINS)
   ) u_detect (
      .clock   (clock),
      .reset_n (reset_n),
      .dif     (dif)
   );

   // power mode tracking; deep stop is left one edge after stop_deep falls,
   // so the unit spends a whole cycle in reset state before running again
   always_comb begin
      pwr_nxt = pwr_r;
      unique case (pwr_r)
         KEL_PWR_RUN: begin
            if (stop_deep) begin
               pwr_nxt = KEL_PWR_DEEP;
            end else if (stop_light) begin
               pwr_nxt = KEL_PWR_LIGHT;
            end
         end
         KEL_PWR_LIGHT: begin
            if (stop_deep) begin
               pwr_nxt = KEL_PWR_DEEP;
            end else if (!stop_light) begin
               pwr_nxt = KEL_PWR_RUN;
            end
         end
         KEL_PWR_DEEP: begin
            if (!stop_deep) begin
               pwr_nxt = KEL_PWR_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pwr_r <= KEL_PWR_RUN;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

   // deep stop holds the flag and all control registers at reset values; the unit wakes as after reset
   assign deep_clear = stop_deep || (pwr_r == KEL_PWR_DEEP);

   // register write decode; an unmapped offset matches nothing, so a write
   // there is dropped and a read of it returns zero
   always_comb begin
      wr_sc   = reg_wr && kel_hit(reg_addr, KEL_OFS_STATUS_CTRL);
      wr_pe   = reg_wr && kel_hit(reg_addr, KEL_OFS_PIN_ENABLE);
      wr_es   = reg_wr && kel_hit(reg_addr, KEL_OFS_POLARITY);
      ack_req = wr_sc && reg_wdata[KEL_SC_ACK_BIT];
   end

   // flag set and clear conditions
   always_comb begin
      edge_any  = |dif.edge_hit;
      level_any = |dif.level_hit;
      set_cond  = edge_any;
      clear_ok  = 1'b1;
      if (mode_r == KEL_MODE_EDGE_LEVEL) begin
         // a key still held down keeps refusing the acknowledge
         set_cond = edge_any || level_any;
         clear_ok = !level_any;
      end
   end

   // detect flag: hardware sets it, only the acknowledge or deep stop clears it
   always_comb begin
      flag_nxt = flag_r;
      if (ack_req && clear_ok) begin
         flag_nxt = 1'b0;
      end
      // a new event in the acknowledge cycle is kept
      if (set_cond) begin
         flag_nxt = 1'b1;
      end
      if (deep_clear) begin
         flag_nxt = KEL_FLAG_RST;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         flag_r <= KEL_FLAG_RST;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   // interrupt enable and detection mode; the flag bit of the write data is ignored
   always_comb begin
      ie_nxt   = ie_r;
      mode_nxt = mode_r;
      if (wr_sc) begin
         ie_nxt   = reg_wdata[KEL_SC_IE_BIT];
         mode_nxt = reg_wdata[KEL_SC_MODE_BIT];
      end
      if (deep_clear) begin
         ie_nxt   = KEL_IE_RST;
         mode_nxt = KEL_MODE_RST;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ie_r   <= KEL_IE_RST;
         mode_r <= KEL_MODE_RST;
      end else begin
         ie_r   <= ie_nxt;
         mode_r <= mode_nxt;
      end
   end

   // pin enables and polarities
   always_comb begin
      pe_nxt = pe_r;
      es_nxt = es_r;
      if (wr_pe) begin
         pe_nxt = reg_wdata[NUM_PINS-1:0];
      end
      if (wr_es) begin
         es_nxt = reg_wdata[NUM_PINS-1:0];
      end
      if (deep_clear) begin
         pe_nxt = KEL_PE_RST[NUM_PINS-1:0];
         es_nxt = KEL_ES_RST[NUM_PINS-1:0];
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pe_r <= KEL_PE_RST[NUM_PINS-1:0];
         es_r <= KEL_ES_RST[NUM_PINS-1:0];
      end else begin
         pe_r <= pe_nxt;
         es_r <= es_nxt;
      end
   end

   // read path: data stands only in the cycle after the strobe, zero otherwise,
   // so a bus that ORs several slaves together needs no extra gating
   always_comb begin
      rdata_nxt = KEL_ZERO;
      if (reg_rd) begin
         unique case (reg_addr)
            KEL_OFS_STATUS_CTRL: begin
               // upper nibble and acknowledge stay zero
               rdata_nxt[KEL_SC_FLAG_BIT] = flag_r;
               rdata_nxt[KEL_SC_IE_BIT]   = ie_r;
               rdata_nxt[KEL_SC_MODE_BIT] = mode_r;
            end
            KEL_OFS_PIN_ENABLE: begin
               rdata_nxt = pin_word(pe_r);
            end
            KEL_OFS_POLARITY: begin
               rdata_nxt = pin_word(es_r);
            end
            default: begin
               rdata_nxt = KEL_ZERO;
            end
         endcase
      end
   end

   // request outputs follow the next register state so they line up with it
   always_comb begin
      irq_nxt = flag_nxt && ie_nxt;
   end

   // a wake is only raised in light stop; deep stop has the unit held in reset
   always_comb begin
      wake_nxt = irq_nxt && (pwr_nxt == KEL_PWR_LIGHT);
   end

   // pull steering: only keyboard-enabled pins take their type from polarity;
   // every other pin keeps the port's ordinary pull-up
   always_comb begin
      pull_up_nxt = '0;
      pull_dn_nxt = '0;
      for (int p = 0; p < NUM_PINS; p++) begin
         if (port_pull_enable[p]) begin
            if (pe_nxt[p] && es_nxt[p]) begin
               pull_dn_nxt[p] = 1'b1;
            end else begin
               pull_up_nxt[p] = 1'b1;
            end
         end
      end
   end

   // read data register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= KEL_ZERO;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // request registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irq_r  <= 1'b0;
         wake_r <= 1'b0;
      end else begin
         irq_r  <= irq_nxt;
         wake_r <= wake_nxt;
      end
   end

   // pad pull registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pull_up_r <= '0;
         pull_dn_r <= '0;
      end else begin
         pull_up_r <= pull_up_nxt;
         pull_dn_r <= pull_dn_nxt;
      end
   end

   assign reg_rdata    = rdata_r;
   assign irq_request  = irq_r;
   assign wake_request = wake_r;
   assign pull_up_en   = pull_up_r;
   assign pull_dn_en   = pull_dn_r;

   // software order mask/polarity/pulls/enables/acknowledge/unmask avoids the
   // false flag that enabling a pin at its asserted level would raise

endmodule

`default_nettype wire

// File: verif/kel_keys.sv
/* Key switches and pads in front of the keypad unit.
   Assumes the bench closes switches and the unit steers the pulls. */
`timescale 1ns/1ps
`default_nettype none
module kel_keys #(
   parameter int NUM_PINS = 8
) (
   input  wire logic                clock_in, // bus clock
   input  wire logic [NUM_PINS-1:0] drive,    // closed switch level
   input  wire logic [NUM_PINS-1:0] drive_en, // switch closed
   input  wire logic [NUM_PINS-1:0] pull_up,  // pad pull-up on
   input  wire logic [NUM_PINS-1:0] pull_dn,  // pad pull-down on
   output logic      [NUM_PINS-1:0] pins      // pad levels
);
   logic [NUM_PINS-1:0] last_r;
   // a floating pad never keeps its last level, so it cannot hide a missing pull
   always_ff @(posedge clock_in) begin
      last_r <= pins;
   end
   assign pins = (drive_en & drive) | (~drive_en & (pull_up | (~pull_dn & ~last_r)));
endmodule
`default_nettype wire

// File: verif/kel_top_asserts.sv
/* Port checker of the keypad interrupt unit.
   Bound to kel_top; one clock domain, async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module kel_top_asserts #(
   parameter int NUM_PINS = 8
) (
   input wire logic                clock,            // bus clock
   input wire logic                reset_n,          // async reset
   input wire kel_pkg::kel_addr_t  reg_addr,         // address
   input wire kel_pkg::kel_byte_t  reg_wdata,        // write data
   input wire logic                reg_wr,           // write strobe
   input wire logic                reg_rd,           // read strobe
   input wire kel_pkg::kel_byte_t  reg_rdata,        // read data
   input wire logic [NUM_PINS-1:0] key_input_pins,   // keys
   input wire logic [NUM_PINS-1:0] port_pull_enable, // pull enables
   input wire logic                stop_light,       // light stop
   input wire logic                stop_deep,        // deep stop
   input wire logic                irq_request,      // request
   input wire logic                wake_request,     // wake
   input wire logic [NUM_PINS-1:0] pull_up_en,       // pull-up
   input wire logic [NUM_PINS-1:0] pull_dn_en        // pull-down
);
   import kel_pkg::*;
   logic sc_wr;
   assign sc_wr = reg_wr && (reg_addr == KEL_OFS_STATUS_CTRL);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == KEL_ZERO)
      else $error("read data not zero outside a read");
   a_sc_reserved: assert property (
      $past(reg_rd) && $past(reg_addr) == KEL_OFS_STATUS_CTRL |-> reg_rdata[7:4] == 4'h0 && !reg_rdata[2])
      else $error("reserved or acknowledge bit read nonzero");
   a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) == 2'h3 |-> reg_rdata == KEL_ZERO)
      else $error("unmapped read nonzero");
   a_pull_steer: assert property (
      $past(reset_n) |-> (pull_up_en | pull_dn_en) == $past(port_pull_enable) && (pull_up_en & pull_dn_en) == '0)
      else $error("pull outputs wrong");
   a_irq_mask: assert property (sc_wr && !reg_wdata[KEL_SC_IE_BIT] |=> !irq_request)
      else $error("request while masked");
   a_irq_sticky: assert property (irq_request && !sc_wr && !stop_deep |=> irq_request)
      else $error("request dropped without acknowledge");
   a_wake_light: assert property ($past(reset_n) |-> wake_request == (irq_request && $past(stop_light)))
      else $error("wake request wrong");
   a_deep_quiet: assert property (stop_deep |=> !irq_request && !wake_request)
      else $error("request during deep stop");
   cover property ($rose(irq_request));
   cover property (wake_request);
   cover property (sc_wr && reg_wdata[KEL_SC_ACK_BIT] && irq_request);
endmodule
bind kel_top kel_top_asserts #(.NUM_PINS(NUM_PINS)) i_kel_top_asserts (
   .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_input_pins(key_input_pins),
   .port_pull_enable(port_pull_enable), .stop_light(stop_light), .stop_deep(stop_deep),
   .irq_request(irq_request), .wake_request(wake_request), .pull_up_en(pull_up_en),
   .pull_dn_en(pull_dn_en));
`default_nettype wire

// File: verif/kel_top_tb.sv
/* Self-checking bench of the keypad interrupt unit.
   Assumes kel_keys stands on the key pins; 125 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module kel_top_tb;
   import kel_pkg::*;
   logic      clock, reset_n, reg_wr, reg_rd, stop_light, stop_deep, irq_request, wake_request;
   kel_addr_t reg_addr;
   kel_byte_t reg_wdata, reg_rdata, key_input_pins, port_pull_enable, pull_up_en, pull_dn_en;
   kel_byte_t drive, drive_en;
   int        failures, checks_done;
   kel_top #(.NUM_PINS(8)) i_kel_top (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .key_input_pins(key_input_pins), .port_pull_enable(port_pull_enable), .stop_light(stop_light),
      .stop_deep(stop_deep), .irq_request(irq_request), .wake_request(wake_request),
      .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en));
   kel_keys #(.NUM_PINS(8)) i_kel_keys (.clock_in(clock), .drive(drive), .drive_en(drive_en),
      .pull_up(pull_up_en), .pull_dn(pull_dn_en), .pins(key_input_pins));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic chk(input kel_byte_t got, input kel_byte_t exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input kel_addr_t a, input kel_byte_t d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input kel_addr_t a, input kel_byte_t e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      chk(reg_rdata, e);
   endtask
   task automatic irq_is(input logic e, input logic w);
      @(negedge clock);
      chk({6'h00, wake_request, irq_request}, {6'h00, w, e});
   endtask
   // switches move after one edge; the next edge samples them
   task automatic pin(input kel_byte_t en, input kel_byte_t lv);
      @(posedge clock);
      drive_en <= en;
      drive <= lv;
      @(posedge clock);
   endtask
   task automatic fin(input string n);
      $display("test %s done", n);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clock);
      failures++;
      $display("mismatch at %0t: run hung", $time);
      stop_test();
   end
   initial begin
      {reset_n, reg_wr, reg_rd, stop_light, stop_deep} = 5'h00;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      port_pull_enable = 8'hFF;
      drive = 8'h00;
      drive_en = 8'h00;
      failures = 0;
      checks_done = 0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      rd(KEL_OFS_STATUS_CTRL, 8'h00);
      rd(KEL_OFS_PIN_ENABLE, 8'h00);
      rd(KEL_OFS_POLARITY, 8'h00);
      fin("reset");
      wr(KEL_OFS_STATUS_CTRL, 8'hFF);
      rd(KEL_OFS_STATUS_CTRL, 8'h03);
      wr(KEL_OFS_STATUS_CTRL, 8'h00);
      wr(KEL_OFS_PIN_ENABLE, 8'h5A);
      rd(KEL_OFS_PIN_ENABLE, 8'h5A);
      wr(KEL_OFS_POLARITY, 8'hA5);
      rd(KEL_OFS_POLARITY, 8'hA5);
      wr(2'h3, 8'hFF);
      rd(2'h3, 8'h00);
      wr(KEL_OFS_PIN_ENABLE, 8'h00);
      wr(KEL_OFS_POLARITY, 8'h00);
      fin("registers");
      wr(KEL_OFS_STATUS_CTRL, 8'h00);
      wr(KEL_OFS_PIN_ENABLE, 8'h01);
      wr(KEL_OFS_STATUS_CTRL, 8'h06);
      irq_is(1'b0, 1'b0);
      chk(pull_up_en, 8'hFF);
      pin(8'h02, 8'h00);
      irq_is(1'b0, 1'b0);
      pin(8'h03, 8'h00);
      irq_is(1'b1, 1'b0);
      rd(KEL_OFS_STATUS_CTRL, 8'h0A);
      wr(KEL_OFS_STATUS_CTRL, 8'h06);
      irq_is(1'b0, 1'b0);
      wr(KEL_OFS_STATUS_CTRL, 8'h00);
      pin(8'h00, 8'h00);
      pin(8'h01, 8'h00);
      irq_is(1'b0, 1'b0);
      rd(KEL_OFS_STATUS_CTRL, 8'h08);
      wr(KEL_OFS_STATUS_CTRL, 8'h02);
      irq_is(1'b1, 1'b0);
      pin(8'h00, 8'h00);
      wr(KEL_OFS_STATUS_CTRL, 8'h06);
      irq_is(1'b0, 1'b0);
      fin("falling");
      wr(KEL_OFS_POLARITY, 8'h01);
      irq_is(1'b0, 1'b0);
      chk(pull_dn_en, 8'h01);
      chk(pull_up_en, 8'hFE);
      pin(8'h01, 8'h01);
      irq_is(1'b1, 1'b0);
      wr(KEL_OFS_STATUS_CTRL, 8'h06);
      repeat (3) @(posedge clock);
      irq_is(1'b0, 1'b0);
      fin("rising");
      wr(KEL_OFS_STATUS_CTRL, 8'h07);
      @(posedge clock);
      irq_is(1'b1, 1'b0);
      wr(KEL_OFS_STATUS_CTRL, 8'h07);
      irq_is(1'b1, 1'b0);
      pin(8'h00, 8'h00);
      irq_is(1'b1, 1'b0);
      wr(KEL_OFS_STATUS_CTRL, 8'h07);
      irq_is(1'b0, 1'b0);
      fin("level");
      @(posedge clock);
      stop_light <= 1'b1;
      pin(8'h01, 8'h01);
      irq_is(1'b1, 1'b1);
      @(posedge clock);
      stop_light <= 1'b0;
      stop_deep <= 1'b1;
      wr(KEL_OFS_PIN_ENABLE, 8'hFF);
      irq_is(1'b0, 1'b0);
      @(posedge clock);
      stop_deep <= 1'b0;
      repeat (2) @(posedge clock);
      rd(KEL_OFS_STATUS_CTRL, 8'h00);
      rd(KEL_OFS_PIN_ENABLE, 8'h00);
      rd(KEL_OFS_POLARITY, 8'h00);
      fin("stop modes");
      stop_test();
   end
endmodule
`default_nettype wire
